// >>> rtl/cfi_top.sv
// fault injection word handling, readback corruption and error flag pin
`timescale 1ns/100ps
`default_nettype none
module cfi_top #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // device status and options
    input wire logic i_user_mode,
    input wire logic i_checker_enable,
    input wire logic i_flag_open_drain,
    input wire logic [cfi_pkg::DIV_SEL_W-1:0] i_div_sel,
    // boundary-scan side
    input wire logic [cfi_pkg::IR_W-1:0] i_scan_instr,
    input wire logic i_scan_update,
    input wire logic [cfi_pkg::WORD_W-1:0] i_scan_word,
    // frame sequencing from the checker
    input wire logic i_frame_window,
    input wire logic i_first_frame,
    input wire logic i_rb_valid,
    input wire logic [cfi_pkg::LOC_W-1:0] i_rb_byte_idx,
    input wire logic [DATA_W-1:0] i_rb_data,
    input wire logic i_frame_done,
    input wire logic [cfi_pkg::SYN_W-1:0] i_syndrome,
    // corrupted readback toward the checker
    output logic o_rb_valid,
    output logic [DATA_W-1:0] o_rb_data,
    // status
    output logic o_test_mode,
    output logic [cfi_pkg::WORD_W-1:0] o_fault_word,
    output logic o_tick,
    // error flag pin and user I/O
    input wire logic i_user_io_out,
    input wire logic i_user_io_oe,
    input wire logic i_flag_pin_in,
    output logic o_user_io_in,
    output logic o_flag_out,
    output logic o_flag_oe
);
    import cfi_pkg::*;
    localparam int NBYTE = DATA_W / 8;

    logic active;
    logic tick;
    assign active = i_user_mode && i_checker_enable;

    cfi_clkdiv u_div (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_enable(active),
        .i_div_sel(i_div_sel),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // injection word: scan holding copy, then internal copy
    logic [WORD_W-1:0] scan_word_q, scan_word_d;
    logic [WORD_W-1:0] fault_word_q, fault_word_d;
    logic pending_q, pending_d;
    logic test_mode_q, test_mode_d;
    logic [1:0] etype;

    always_comb begin
        scan_word_d = scan_word_q;
        pending_d = pending_q;
        fault_word_d = fault_word_q;
        test_mode_d = test_mode_q;
        // hold the copy off across the last/first frame window
        if (pending_q && !i_frame_window) begin
            fault_word_d = scan_word_q;
            pending_d = 1'b0;
        end
        // instruction ignored outside user mode; a load in the copy cycle
        // keeps pending set so the newer word follows one cycle later
        if (i_scan_update && i_user_mode && i_scan_instr == INJECT_FAULT_INSTRUCTION) begin
            scan_word_d = i_scan_word;
            pending_d = 1'b1;
        end
        // first frame consumed with injection armed: test mode entered
        if (i_frame_done && i_first_frame) begin
            test_mode_d = (fault_word_q[TYPE_HI:TYPE_LO] == TYPE_SINGLE)
                       || (fault_word_q[TYPE_HI:TYPE_LO] == TYPE_DOUBLE);
        end
        if (!i_user_mode) begin
            pending_d = 1'b0;
            fault_word_d = WORD_RESET;
            test_mode_d = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            scan_word_q <= WORD_RESET;
            pending_q <= 1'b0;
            fault_word_q <= WORD_RESET;
            test_mode_q <= 1'b0;
        end else begin
            scan_word_q <= scan_word_d;
            pending_q <= pending_d;
            fault_word_q <= fault_word_d;
            test_mode_q <= test_mode_d;
        end
    end

    // 11 is not a legal type and falls back to no injection
    always_comb begin
        unique case (fault_word_q[TYPE_HI:TYPE_LO])
            TYPE_SINGLE: etype = TYPE_SINGLE;
            TYPE_DOUBLE: etype = TYPE_DOUBLE;
            default: etype = TYPE_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // readback corruption: xor on the data path only, cells untouched
    logic [NBYTE-1:0] hit;
    logic [DATA_W-1:0] rb_data_q, rb_data_d;
    logic rb_valid_q, rb_valid_d;
    logic [LOC_W-1:0] loc;
    assign loc = fault_word_q[LOC_HI:LOC_LO];

    genvar gb;
    generate
        for (gb = 0; gb < NBYTE; gb++) begin : g_byte
            logic [LOC_W-1:0] idx;
            assign idx = i_rb_byte_idx + LOC_W'(gb);
            // double mode also hits the byte after the addressed one
            assign hit[gb] = active && i_first_frame && etype != TYPE_NONE
                && (idx == loc || (etype == TYPE_DOUBLE && idx == loc + 1'b1));
            assign rb_data_d[gb*8 +: 8] = i_rb_data[gb*8 +: 8]
                ^ (hit[gb] ? fault_word_q[VAL_HI:VAL_LO] : 8'h00);
        end
    endgenerate
    assign rb_valid_d = i_rb_valid;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rb_data_q <= '0;
            rb_valid_q <= 1'b0;
        end else begin
            rb_data_q <= rb_data_d;
            rb_valid_q <= rb_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error flag: high on bad frame, then low for a guaranteed gap
    cfi_flag_state_t st_q, st_d;
    logic [5:0] gap_q, gap_d;
    logic err_pend_q, err_pend_d;

    always_comb begin
        st_d = st_q;
        gap_d = gap_q;
        err_pend_d = err_pend_q;
        // a new bad frame is never dropped while the gap runs
        if (i_frame_done && i_syndrome != '0) begin
            err_pend_d = 1'b1;
        end
        unique case (st_q)
            CFI_IDLE: begin
                if (err_pend_q) begin
                    st_d = CFI_HIGH;
                    err_pend_d = i_frame_done && i_syndrome != '0;
                end
            end
            CFI_HIGH: begin
                if (tick) begin
                    st_d = CFI_LOW;
                    gap_d = '0;
                end
            end
            CFI_LOW: begin
                if (tick) begin
                    gap_d = gap_q + 1'b1;
                end
                if (tick && gap_q == 6'(FLAG_LOW_MIN - 1)) begin
                    st_d = CFI_IDLE;
                end
            end
            default: st_d = CFI_IDLE;
        endcase
        if (!active) begin
            st_d = CFI_IDLE;
            err_pend_d = 1'b0;
            gap_d = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            st_q <= CFI_IDLE;
            gap_q <= '0;
            err_pend_q <= 1'b0;
        end else begin
            st_q <= st_d;
            gap_q <= gap_d;
            err_pend_q <= err_pend_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin muxing
    logic flag;
    assign flag = (st_q == CFI_HIGH);
    always_comb begin
        if (!i_checker_enable) begin
            o_flag_out = i_user_io_out;
            o_flag_oe = i_user_io_oe;
        end else if (i_flag_open_drain) begin
            o_flag_out = 1'b0;
            o_flag_oe = !flag;
        end else begin
            o_flag_out = flag;
            o_flag_oe = 1'b1;
        end
    end
    assign o_user_io_in = i_checker_enable ? 1'b0 : i_flag_pin_in;

    assign o_rb_valid = rb_valid_q;
    assign o_rb_data = rb_data_q;
    assign o_test_mode = test_mode_q;
    assign o_fault_word = fault_word_q;
    assign o_tick = tick;
endmodule // cfi_top
`default_nettype wire

// >>> rtl/cfi_pkg.sv
// package for the configuration-cell fault injection and error flag block
// Contract
// - inject only in user mode after configuration
// - instruction code 0x015 selects injection word
// - valid word flips readback bits, enters test
// - no copy during last/first frame window
// - inject in first frame only; status readable
// - word fields type 20:19, loc 18:8, val 7:0
// - 01 single, 10 double adjacent, 00 none
// - type 11 decodes as no injection
// - byte value marks flipped bit positions
// - error flag active high on corruption
// - flag pin is user I/O when checker off
// - flag push-pull default, open-drain option
// - inject in-system, then detect real upsets
// - non-zero syndrome raises the error flag
// - flag low at least 32 clocks between reports
// - detection clock is oscillator divided 2..256
package cfi_pkg;
    localparam int IR_W = 10;
    localparam logic [IR_W-1:0] INJECT_FAULT_INSTRUCTION = 10'h015;
    localparam int WORD_W = 21;
    localparam int TYPE_HI = 20;
    localparam int TYPE_LO = 19;
    localparam int LOC_HI = 18;
    localparam int LOC_LO = 8;
    localparam int VAL_HI = 7;
    localparam int VAL_LO = 0;
    localparam int LOC_W = LOC_HI - LOC_LO + 1;
    localparam int SYN_W = 16;
    localparam logic [WORD_W-1:0] WORD_RESET = 21'h00_0000;
    localparam logic [1:0] TYPE_NONE = 2'h0;
    localparam logic [1:0] TYPE_SINGLE = 2'h1;
    localparam logic [1:0] TYPE_DOUBLE = 2'h2;
    localparam int FLAG_LOW_MIN = 32;
    localparam int OSC_MHZ = 100;
    localparam int DIV_MIN_LOG2 = 1;
    localparam int DIV_MAX_LOG2 = 8;
    localparam int DIV_SEL_W = 3;
    localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET = 3'h0;
    typedef enum logic [2:0] {
        CFI_IDLE = 3'b001,
        CFI_LOW  = 3'b010,
        CFI_HIGH = 3'b100
    } cfi_flag_state_t;
endpackage

// >>> rtl/cfi_clkdiv.sv
// detection clock tick generator: divides the oscillator by 2^(sel+1)
`timescale 1ns/100ps
`default_nettype none
module cfi_clkdiv (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // control
    input wire logic i_enable,
    input wire logic [cfi_pkg::DIV_SEL_W-1:0] i_div_sel,
    // tick
    output logic o_tick
);
    import cfi_pkg::*;
    logic [DIV_MAX_LOG2-1:0] cnt_q, cnt_d;
    logic [DIV_MAX_LOG2-1:0] limit;
    logic tick_q, tick_d;

    // limit = 2^(sel+1) - 1; sel 0..7 covers divide 2..256
    // shift amount widened so that sel 7 does not wrap to a zero shift
    assign limit = DIV_MAX_LOG2'((9'h001 << (4'(i_div_sel) + 4'(DIV_MIN_LOG2))) - 9'h001);

    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (i_enable) begin
            if (cnt_q >= limit) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end else begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;
endmodule // cfi_clkdiv
`default_nettype wire

// >>> verification/cfi_scan_host.sv
// boundary-scan host model and the error flag pin with its pull-up
`timescale 1ns/100ps
`default_nettype none
module cfi_scan_host (
    // clock
    input wire logic i_mclk,
    // flag pin drive from the device
    input wire logic i_flag_out,
    input wire logic i_flag_oe,
    // scan side and options toward the device
    output logic [cfi_pkg::IR_W-1:0] o_scan_instr,
    output logic o_scan_update,
    output logic [cfi_pkg::WORD_W-1:0] o_scan_word,
    output logic [cfi_pkg::DIV_SEL_W-1:0] o_div_sel,
    output logic o_pin
);
    import cfi_pkg::*;
    // injection is only tried at the fastest rate, oscillator over two
    assign o_div_sel = 3'h0;
    // a released pin floats up through the external resistor
    assign o_pin = i_flag_oe ? i_flag_out : 1'b1;
    initial begin
        o_scan_instr = 10'h000;
        o_scan_update = 1'b0;
        o_scan_word = 21'h00_0000;
    end
    task automatic load(input logic [IR_W-1:0] ir, input logic [WORD_W-1:0] w);
        @(posedge i_mclk);
        #1;
        o_scan_instr = ir;
        o_scan_word = w;
        o_scan_update = 1'b1;
        @(posedge i_mclk);
        #1;
        o_scan_update = 1'b0;
        // the chain shifts on once update is over, so the old word is gone
        o_scan_word = ~w;
    endtask
endmodule // cfi_scan_host
`default_nettype wire

// >>> verification/cfi_top_chk.sv
// assertions on the fault injection and error flag ports
`timescale 1ns/100ps
`default_nettype none
module cfi_top_chk #(
    parameter int DATA_W = 16
) (
    input wire logic i_mclk, i_reset, i_user_mode, i_checker_enable, i_flag_open_drain,
    input wire logic [cfi_pkg::DIV_SEL_W-1:0] i_div_sel,
    input wire logic [cfi_pkg::IR_W-1:0] i_scan_instr,
    input wire logic i_scan_update, i_frame_window, i_first_frame, i_rb_valid, i_frame_done,
    input wire logic [cfi_pkg::WORD_W-1:0] i_scan_word, o_fault_word,
    input wire logic [DATA_W-1:0] i_rb_data, o_rb_data,
    input wire logic [cfi_pkg::SYN_W-1:0] i_syndrome,
    input wire logic o_tick, i_user_io_out, i_user_io_oe, i_flag_pin_in, o_user_io_in, o_flag_out, o_flag_oe
);
    import cfi_pkg::*;
    logic [5:0] gap_q, gap_d;
    wire logic flag = i_flag_open_drain ? !o_flag_oe : o_flag_out;
    wire logic run = i_checker_enable && i_user_mode;
    // ticks seen with the flag low since its last report
    always_comb begin
        gap_d = gap_q;
        if (!run || i_reset) begin
            gap_d = 6'h20;
        end else if (flag) begin
            gap_d = 6'h00;
        end else if (o_tick && gap_q != 6'h3f) begin
            gap_d = gap_q + 6'h01;
        end
    end
    always_ff @(posedge i_mclk) begin
        gap_q <= gap_d;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence s_take;
        i_scan_update && i_user_mode && i_scan_instr == INJECT_FAULT_INSTRUCTION;
    endsequence
    sequence s_quiet;
        !i_frame_window && i_user_mode && !i_scan_update;
    endsequence
    property p_load;
        s_take ##1 s_quiet |=> o_fault_word == $past(i_scan_word, 2);
    endproperty
    a_load: assert property (p_load) else $error("word not copied");
    property p_hold;
        o_fault_word != $past(o_fault_word) && $past(i_user_mode) |-> !$past(i_frame_window);
    endproperty
    a_hold: assert property (p_hold) else $error("copy inside window");
    property p_leave;
        !i_user_mode |=> o_fault_word == WORD_RESET;
    endproperty
    a_leave: assert property (p_leave) else $error("word kept out of user mode");
    property p_plain;
        i_rb_valid && (o_fault_word[TYPE_HI] == o_fault_word[TYPE_LO] || !i_first_frame) |=> o_rb_data == $past(i_rb_data);
    endproperty
    a_plain: assert property (p_plain) else $error("readback altered");
    property p_push;
        i_checker_enable && !i_flag_open_drain |-> o_flag_oe;
    endproperty
    a_push: assert property (p_push) else $error("flag not driven");
    property p_drain;
        i_checker_enable && i_flag_open_drain |-> !o_flag_out;
    endproperty
    a_drain: assert property (p_drain) else $error("open drain drives high");
    property p_user;
        !i_checker_enable |-> o_flag_oe == i_user_io_oe && o_flag_out == i_user_io_out && o_user_io_in == i_flag_pin_in;
    endproperty
    a_user: assert property (p_user) else $error("pin not user io");
    property p_rise;
        i_frame_done && i_syndrome != '0 && run |-> ##[1:400] flag;
    endproperty
    a_rise: assert property (p_rise) else $error("error not flagged");
    property p_gap;
        $rose(flag) |-> gap_q >= 6'h20;
    endproperty
    a_gap: assert property (p_gap) else $error("flag low too short");
    property p_tick;
        o_tick && run && i_div_sel == 3'h0 |=> !o_tick ##1 (o_tick || !run);
    endproperty
    a_tick: assert property (p_tick) else $error("tick rate wrong");
endmodule // cfi_top_chk
bind cfi_top cfi_top_chk #(.DATA_W(DATA_W)) cfi_top_chk_i (.*);
`default_nettype wire

// >>> verification/cfi_top_bench.sv
// self-checking bench for the fault injection and error flag block
`timescale 1ns/100ps
`default_nettype none
module cfi_top_bench;
    import cfi_pkg::*;
    logic i_mclk = 1'b0, i_reset = 1'b1, i_user_mode = 1'b0, i_checker_enable = 1'b1;
    logic i_flag_open_drain = 1'b0, i_frame_window = 1'b0, i_first_frame = 1'b0, i_rb_valid = 1'b0;
    logic i_frame_done = 1'b0, i_user_io_out = 1'b0, i_user_io_oe = 1'b0, i_scan_update, i_flag_pin_in;
    logic [10:0] i_rb_byte_idx = 11'h000;
    logic [15:0] i_rb_data = 16'h0000, i_syndrome = 16'h0000, o_rb_data;
    logic [IR_W-1:0] i_scan_instr;
    logic [WORD_W-1:0] i_scan_word, o_fault_word, w;
    logic [DIV_SEL_W-1:0] i_div_sel;
    logic o_rb_valid, o_test_mode, o_tick, o_user_io_in, o_flag_out, o_flag_oe;
    int miscompares = 0, n_compared = 0, n;
    always #5 i_mclk = ~i_mclk;
    cfi_top cfi_top_i (.*);
    cfi_scan_host cfi_scan_host_i (.i_mclk(i_mclk), .i_flag_out(o_flag_out), .i_flag_oe(o_flag_oe),
        .o_scan_instr(i_scan_instr), .o_scan_update(i_scan_update), .o_scan_word(i_scan_word),
        .o_div_sel(i_div_sel), .o_pin(i_flag_pin_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge i_mclk);
        #1;
    endtask
    task automatic done_pulse();
        i_frame_done = 1'b1;
        step(1);
        i_frame_done = 1'b0;
    endtask
    task automatic beat(input logic [10:0] idx, input logic [15:0] d, input logic [15:0] exp);
        i_rb_valid = 1'b1;
        i_rb_byte_idx = idx;
        i_rb_data = d;
        step(1);
        chk(o_rb_data, exp);
        chk(o_rb_valid, 1'b1);
        i_rb_valid = 1'b0;
        i_rb_data = ~d;
        // let an edge see valid low before the next beat raises it again
        step(1);
        chk(o_rb_valid, 1'b0);
    endtask
    // a hang on the flag pin is cut short here
    task automatic wait_pin(input logic lvl, input int lim);
        for (n = 1; n <= lim; n++) begin
            step(1);
            if (i_flag_pin_in === lvl)
                return;
        end
        miscompares++;
        $display("Error at %0t: flag pin wait ran out", $time);
        final_report();
    endtask
    function automatic logic [15:0] corrupt(input logic [20:0] v, input logic [10:0] idx, input logic [15:0] d);
        logic [15:0] r;
        r = d;
        for (int b = 0; b < 2; b++)
            if ((v[20:19] == 2'h1 && idx + b == v[18:8]) ||
                (v[20:19] == 2'h2 && (idx + b == v[18:8] || idx + b == v[18:8] + 1)))
                r[8*b +: 8] = r[8*b +: 8] ^ v[7:0];
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(10);
        i_reset = 1'b0;
        chk(o_flag_out, 1'b0);
        cfi_scan_host_i.load(INJECT_FAULT_INSTRUCTION, 21'h08_05A5);
        step(3);
        chk(o_fault_word, 21'h00_0000);
        i_user_mode = 1'b1;
        cfi_scan_host_i.load(10'h016, 21'h08_05A5);
        step(3);
        chk(o_fault_word, 21'h00_0000);
        i_frame_window = 1'b1;
        cfi_scan_host_i.load(INJECT_FAULT_INSTRUCTION, 21'h08_05A5);
        step(4);
        chk(o_fault_word, 21'h00_0000);
        i_frame_window = 1'b0;
        step(2);
        chk(o_fault_word, 21'h08_05A5);
        for (int t = 0; t < 4; t++) begin
            w = {t[1:0], 11'h005, 8'hA5};
            cfi_scan_host_i.load(INJECT_FAULT_INSTRUCTION, w);
            step(2);
            chk(o_fault_word, w);
            i_first_frame = 1'b1;
            for (int i = 4; i < 7; i++)
                beat(i[10:0], 16'h1234, corrupt(w, i[10:0], 16'h1234));
            done_pulse();
            i_first_frame = 1'b0;
            step(2);
            chk(o_test_mode, t == 1 || t == 2);
            beat(11'h005, 16'h1234, 16'h1234);
        end
        i_user_mode = 1'b0;
        step(1);
        chk(o_fault_word, 21'h00_0000);
        i_reset = 1'b1;
        step(2);
        i_reset = 1'b0;
        i_user_mode = 1'b1;
        i_syndrome = 16'h0001;
        done_pulse();
        wait_pin(1'b1, 50);
        chk(o_flag_oe, 1'b1);
        i_flag_open_drain = 1'b1;
        done_pulse();
        wait_pin(1'b0, 10);
        wait_pin(1'b1, 200);
        chk(n >= 64, 1'b1);
        chk(o_flag_out, 1'b0);
        i_checker_enable = 1'b0;
        i_user_io_oe = 1'b1;
        i_user_io_out = 1'b1;
        step(1);
        chk(o_user_io_in, 1'b1);
        i_user_io_out = 1'b0;
        step(1);
        chk(i_flag_pin_in, 1'b0);
        chk(o_user_io_in, 1'b0);
        final_report();
    end
endmodule // cfi_top_bench
`default_nettype wire
